// ==== hdl/clock_gen_pkg.sv ====
package clock_gen_pkg;

   // serial address of this device (value is arbitrary)
   localparam logic [6:0] DEVICE_ADDR = 7'h2a;

   // reset contents of the two decoded configuration bytes
   localparam logic [7:0] FUNC_MODE_RESET = 8'h00;
   localparam logic [7:0] FREQ_CODE_RESET = 8'h07;

   // field positions
   localparam int FUNC_SEL_LSB = 0;
   localparam int FUNC_SEL_MSB = 1;
   localparam int OVERRIDE_LSB = 4;
   localparam int OVERRIDE_MSB = 5;
   localparam int FREQ_SEL_LSB = 0;
   localparam int FREQ_SEL_MSB = 2;

   // byte numbering after the address byte
   localparam logic [3:0] BYTE_FUNC = 4'h0;
   localparam logic [3:0] BYTE_FREQ = 4'h7;
   localparam logic [3:0] BYTE_PAST_END = 4'h8;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;

   // frequency select codes
   localparam logic [2:0] SEL_75_A = 3'h0;
   localparam logic [2:0] SEL_75_B = 3'h1;
   localparam logic [2:0] SEL_83 = 3'h2;
   localparam logic [2:0] SEL_33 = 3'h3;
   localparam logic [2:0] SEL_50 = 3'h4;
   localparam logic [2:0] SEL_68 = 3'h5;
   localparam logic [2:0] SEL_60 = 3'h6;
   localparam logic [2:0] SEL_PIN = 3'h7;

   // frequencies in kHz
   localparam logic [16:0] KHZ_75_00 = 17'h124f8;
   localparam logic [16:0] KHZ_83_31 = 17'h1456e;
   localparam logic [16:0] KHZ_33_41 = 17'h08282;
   localparam logic [16:0] KHZ_50_11 = 17'h0c3be;
   localparam logic [16:0] KHZ_68_52 = 17'h10ba8;
   localparam logic [16:0] KHZ_60_00 = 17'h0ea60;
   localparam logic [16:0] KHZ_66_82 = 17'h10504;
   localparam logic [16:0] KHZ_66_60 = 17'h10428;
   localparam logic [16:0] KHZ_32_00 = 17'h07d00;
   localparam logic [16:0] KHZ_14_318 = 17'h037ee;
   localparam logic [16:0] KHZ_48_00 = 17'h0bb80;
   localparam logic [16:0] KHZ_24_00 = 17'h05dc0;
   localparam logic [16:0] KHZ_NONE = 17'h00000;

   // crystal divide ratios used in test mode, zero when not dividing
   localparam logic [2:0] DIV_NONE = 3'h0;
   localparam logic [2:0] DIV_BY1 = 3'h1;
   localparam logic [2:0] DIV_BY2 = 3'h2;
   localparam logic [2:0] DIV_BY4 = 3'h4;

   typedef enum logic [1:0] {
      FUNC_NORMAL = 2'h0,
      FUNC_TEST = 2'h1,
      FUNC_SPREAD = 2'h2,
      FUNC_HIZ = 2'h3
   } func_mode_e;

   typedef enum logic [1:0] {
      SPREAD_OFF = 2'h0,
      SPREAD_CENTRE = 2'h1,
      SPREAD_DOWN = 2'h2
   } spread_mode_e;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ADDR = 4'h2,
      ST_DATA = 4'h4,
      ST_IGNORE = 4'h8
   } link_state_e;

endpackage

// ==== hdl/two_flop_sync.sv ====
`timescale 1ns/10ps
module two_flop_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic async_in,
   output logic sync_out
);

   logic meta;

   // two stages, the first read by the second only
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         meta <= RESET_VAL;
         sync_out <= RESET_VAL;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule

// ==== hdl/clock_gen_serial_config_select.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - no override: byte 7 code picks frequency
// - bus clock half, codes 001/010 fixed 32
// - override bits set: pin picks 60/66.6
// - byte 0 bits 1:0 pick output function
// - test mode: crystal divided by 2/4/1
// - lines only pulled low or released
// - write only, acknowledge is only drive
// - data change while clock high: start/stop
// - acknowledge after our write address byte and after every data byte
// - data taken only after start and address
// - each bit takes effect on arrival
// - early end: the stop clock rise writes the next bit, later bits unchanged
// - stop or repeated start ends the write
module clock_gen_serial_config_select #(
   parameter logic [6:0] DEVICE_ADDR = clock_gen_pkg::DEVICE_ADDR,
   parameter logic [7:0] FUNC_MODE_RESET = clock_gen_pkg::FUNC_MODE_RESET,
   parameter logic [7:0] FREQ_CODE_RESET = clock_gen_pkg::FREQ_CODE_RESET
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic serial_clock_line,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe,
   input wire logic freq_select_pin,
   input wire logic usb_48_select,
   output logic [7:0] function_and_frequency_mode,
   output logic [7:0] frequency_code_select,
   output logic [1:0] function_mode,
   output logic outputs_hiz,
   output logic test_mode,
   output logic [1:0] spread_mode,
   output logic [16:0] proc_freq_khz,
   output logic [16:0] bus_freq_khz,
   output logic [16:0] ref_freq_khz,
   output logic [16:0] usb_freq_khz,
   output logic [2:0] proc_test_div,
   output logic [2:0] bus_test_div,
   output logic [2:0] ref_test_div,
   output logic [2:0] usb_test_div,
   output logic frame_active
);

   ////////////////////////////////////////////////////////////////////////////
   // link clock domain

   logic link_bit;

   // data bit caught on the rising serial clock, held a whole clock period
   always_ff @(posedge serial_clock_line)
   begin
      link_bit <= serial_data_line_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic scl_s;
   logic sda_s;
   logic fs_s;
   logic usb_s;
   logic scl_d;
   logic sda_d;

   two_flop_sync #(.RESET_VAL(1'b1)) u_scl_sync (
      .clk(mclk),
      .resetn(resetn),
      .async_in(serial_clock_line),
      .sync_out(scl_s)
   );

   two_flop_sync #(.RESET_VAL(1'b1)) u_sda_sync (
      .clk(mclk),
      .resetn(resetn),
      .async_in(serial_data_line_in),
      .sync_out(sda_s)
   );

   two_flop_sync #(.RESET_VAL(1'b0)) u_fs_sync (
      .clk(mclk),
      .resetn(resetn),
      .async_in(freq_select_pin),
      .sync_out(fs_s)
   );

   two_flop_sync #(.RESET_VAL(1'b1)) u_usb_sync (
      .clk(mclk),
      .resetn(resetn),
      .async_in(usb_48_select),
      .sync_out(usb_s)
   );

   // previous synchronised line levels for edge finding
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line events

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
   // a repeated start closes the write just as a stop does
   wire frame_end = start_cond | stop_cond;

   ////////////////////////////////////////////////////////////////////////////
   // byte engine state

   clock_gen_pkg::link_state_e state;
   clock_gen_pkg::link_state_e next_state;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [3:0] byte_idx;
   logic [3:0] next_byte_idx;
   logic [7:0] addr_sr;
   logic ack_wanted;
   logic next_ack_wanted;
   logic ack_drive;
   logic next_ack_drive;

   wire in_addr = (state == clock_gen_pkg::ST_ADDR);
   wire in_data = (state == clock_gen_pkg::ST_DATA);
   wire counting = in_addr | in_data;
   wire ack_slot = (bit_cnt == clock_gen_pkg::BITS_PER_BYTE);
   // link_bit has been stable for two mclk cycles when the rise is seen
   wire data_bit = counting & scl_rise & ~ack_slot;
   wire byte_done = counting & scl_rise & ack_slot;
   wire last_bit = data_bit & (bit_cnt == clock_gen_pkg::LAST_DATA_BIT);
   wire [7:0] addr_full = {addr_sr[6:0], link_bit};
   // only a write to our address is answered
   wire addr_match = (addr_full[7:1] == DEVICE_ADDR) & ~addr_full[0];
   wire [2:0] bit_pos = 3'(clock_gen_pkg::LAST_DATA_BIT - bit_cnt);

   // frame state steps
   always_comb
   begin
      next_state = state;
      if (start_cond)
         next_state = clock_gen_pkg::ST_ADDR;
      else if (stop_cond)
         next_state = clock_gen_pkg::ST_IDLE;
      else
      begin
         case (state)
            clock_gen_pkg::ST_IDLE:
               next_state = clock_gen_pkg::ST_IDLE;
            clock_gen_pkg::ST_ADDR:
               if (byte_done)
                  next_state = ack_wanted ? clock_gen_pkg::ST_DATA
                                          : clock_gen_pkg::ST_IGNORE;
            clock_gen_pkg::ST_DATA:
               next_state = clock_gen_pkg::ST_DATA;
            clock_gen_pkg::ST_IGNORE:
               next_state = clock_gen_pkg::ST_IGNORE;
            default:
               next_state = clock_gen_pkg::ST_IDLE;
         endcase
      end
   end

   // bit and byte counting, nine clocks per byte with the acknowledge
   always_comb
   begin
      next_bit_cnt = bit_cnt;
      next_byte_idx = byte_idx;
      if (frame_end)
      begin
         next_bit_cnt = 4'h0;
         next_byte_idx = clock_gen_pkg::BYTE_FUNC;
      end
      else if (byte_done)
      begin
         next_bit_cnt = 4'h0;
         if (in_data && byte_idx != clock_gen_pkg::BYTE_PAST_END)
            next_byte_idx = 4'(byte_idx + 4'h1);
      end
      else if (data_bit)
         next_bit_cnt = 4'(bit_cnt + 4'h1);
   end

   // acknowledge decision and data line drive
   always_comb
   begin
      next_ack_wanted = ack_wanted;
      next_ack_drive = ack_drive;
      if (frame_end)
      begin
         next_ack_wanted = 1'b0;
         next_ack_drive = 1'b0;
      end
      else
      begin
         if (last_bit)
            next_ack_wanted = in_data | addr_match;
         else if (byte_done && in_data)
            next_ack_wanted = 1'b0;
         if (scl_fall && ack_slot && ack_wanted && counting)
            next_ack_drive = 1'b1;
         else if (scl_fall && bit_cnt == 4'h0)
            next_ack_drive = 1'b0;
      end
   end

   // engine registers
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         state <= clock_gen_pkg::ST_IDLE;
         bit_cnt <= 4'h0;
         byte_idx <= 4'h0;
         ack_wanted <= 1'b0;
         ack_drive <= 1'b0;
      end
      else
      begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         byte_idx <= next_byte_idx;
         ack_wanted <= next_ack_wanted;
         ack_drive <= next_ack_drive;
      end
   end

   // address bits gathered, most significant first
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         addr_sr <= 8'h00;
      else if (start_cond)
         addr_sr <= 8'h00;
      else if (in_addr && data_bit)
         addr_sr <= addr_full;
   end

   // open-drain: the line is only ever pulled low, never driven high
   assign serial_data_line_out = 1'b0;
   assign serial_data_line_oe = ack_drive;
   assign frame_active = ~(state == clock_gen_pkg::ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // configuration bytes, written bit by bit

   logic [7:0] func_reg;
   logic [7:0] freq_reg;
   logic [7:0] next_func;
   logic [7:0] next_freq;

   wire wr_func = in_data & data_bit & (byte_idx == clock_gen_pkg::BYTE_FUNC);
   wire wr_freq = in_data & data_bit & (byte_idx == clock_gen_pkg::BYTE_FREQ);

   // only the arriving bit changes, all others keep their value
   always_comb
   begin
      next_func = func_reg;
      next_freq = freq_reg;
      if (wr_func)
         next_func[bit_pos] = link_bit;
      if (wr_freq)
         next_freq[bit_pos] = link_bit;
   end

   // no shadow copy: values go live as each bit lands
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         func_reg <= FUNC_MODE_RESET;
         freq_reg <= FREQ_CODE_RESET;
      end
      else
      begin
         func_reg <= next_func;
         freq_reg <= next_freq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frequency decode

   wire override = |func_reg[clock_gen_pkg::OVERRIDE_MSB:clock_gen_pkg::OVERRIDE_LSB];
   wire [2:0] sel = freq_reg[clock_gen_pkg::FREQ_SEL_MSB:clock_gen_pkg::FREQ_SEL_LSB];
   wire [1:0] func_sel = func_reg[clock_gen_pkg::FUNC_SEL_MSB:clock_gen_pkg::FUNC_SEL_LSB];
   wire bus_fixed = ~override & ((sel == clock_gen_pkg::SEL_75_B)
                                 | (sel == clock_gen_pkg::SEL_83));
   logic [16:0] sel_khz;

   // processor and memory frequency from the select code or the pin
   always_comb
   begin
      sel_khz = clock_gen_pkg::KHZ_60_00;
      if (override)
         sel_khz = fs_s ? clock_gen_pkg::KHZ_66_60 : clock_gen_pkg::KHZ_60_00;
      else
      begin
         case (sel)
            clock_gen_pkg::SEL_75_A: sel_khz = clock_gen_pkg::KHZ_75_00;
            clock_gen_pkg::SEL_75_B: sel_khz = clock_gen_pkg::KHZ_75_00;
            clock_gen_pkg::SEL_83: sel_khz = clock_gen_pkg::KHZ_83_31;
            clock_gen_pkg::SEL_33: sel_khz = clock_gen_pkg::KHZ_33_41;
            clock_gen_pkg::SEL_50: sel_khz = clock_gen_pkg::KHZ_50_11;
            clock_gen_pkg::SEL_68: sel_khz = clock_gen_pkg::KHZ_68_52;
            clock_gen_pkg::SEL_60: sel_khz = clock_gen_pkg::KHZ_60_00;
            clock_gen_pkg::SEL_PIN:
               sel_khz = fs_s ? clock_gen_pkg::KHZ_66_82 : clock_gen_pkg::KHZ_60_00;
            default: sel_khz = clock_gen_pkg::KHZ_60_00;
         endcase
      end
   end

   wire [16:0] sel_bus_khz = bus_fixed ? clock_gen_pkg::KHZ_32_00
                                       : {1'b0, sel_khz[16:1]};
   wire [16:0] usb_khz = usb_s ? clock_gen_pkg::KHZ_48_00 : clock_gen_pkg::KHZ_24_00;
   wire [2:0] usb_div = usb_s ? clock_gen_pkg::DIV_BY2 : clock_gen_pkg::DIV_BY4;
   wire [1:0] spread_sel = override & fs_s ? clock_gen_pkg::SPREAD_DOWN
                                           : clock_gen_pkg::SPREAD_CENTRE;

   ////////////////////////////////////////////////////////////////////////////
   // output function

   logic [1:0] next_spread;
   logic [16:0] next_proc;
   logic [16:0] next_bus;
   logic [16:0] next_ref;
   logic [16:0] next_usb;
   logic [2:0] next_proc_div;
   logic [2:0] next_bus_div;
   logic [2:0] next_ref_div;
   logic [2:0] next_usb_div;

   // selects what each output group carries in the chosen function
   always_comb
   begin
      next_spread = clock_gen_pkg::SPREAD_OFF;
      next_proc = clock_gen_pkg::KHZ_NONE;
      next_bus = clock_gen_pkg::KHZ_NONE;
      next_ref = clock_gen_pkg::KHZ_NONE;
      next_usb = clock_gen_pkg::KHZ_NONE;
      next_proc_div = clock_gen_pkg::DIV_NONE;
      next_bus_div = clock_gen_pkg::DIV_NONE;
      next_ref_div = clock_gen_pkg::DIV_NONE;
      next_usb_div = clock_gen_pkg::DIV_NONE;
      case (func_sel)
         clock_gen_pkg::FUNC_NORMAL:
         begin
            next_proc = sel_khz;
            next_bus = sel_bus_khz;
            next_ref = clock_gen_pkg::KHZ_14_318;
            next_usb = usb_khz;
         end
         clock_gen_pkg::FUNC_TEST:
         begin
            next_proc_div = clock_gen_pkg::DIV_BY2;
            next_bus_div = clock_gen_pkg::DIV_BY4;
            next_ref_div = clock_gen_pkg::DIV_BY1;
            next_usb_div = usb_div;
         end
         clock_gen_pkg::FUNC_SPREAD:
         begin
            next_spread = spread_sel;
            next_proc = sel_khz;
            next_bus = sel_bus_khz;
            next_ref = clock_gen_pkg::KHZ_14_318;
            next_usb = usb_khz;
         end
         clock_gen_pkg::FUNC_HIZ:
            next_spread = clock_gen_pkg::SPREAD_OFF;
         default:
            next_spread = clock_gen_pkg::SPREAD_OFF;
      endcase
   end

   // decoded outputs registered
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         function_mode <= clock_gen_pkg::FUNC_NORMAL;
         outputs_hiz <= 1'b0;
         test_mode <= 1'b0;
         spread_mode <= clock_gen_pkg::SPREAD_OFF;
         proc_freq_khz <= clock_gen_pkg::KHZ_NONE;
         bus_freq_khz <= clock_gen_pkg::KHZ_NONE;
         ref_freq_khz <= clock_gen_pkg::KHZ_NONE;
         usb_freq_khz <= clock_gen_pkg::KHZ_NONE;
      end
      else
      begin
         function_mode <= func_sel;
         outputs_hiz <= (func_sel == clock_gen_pkg::FUNC_HIZ);
         test_mode <= (func_sel == clock_gen_pkg::FUNC_TEST);
         spread_mode <= next_spread;
         proc_freq_khz <= next_proc;
         bus_freq_khz <= next_bus;
         ref_freq_khz <= next_ref;
         usb_freq_khz <= next_usb;
      end
   end

   // test dividers and byte mirrors registered
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         proc_test_div <= clock_gen_pkg::DIV_NONE;
         bus_test_div <= clock_gen_pkg::DIV_NONE;
         ref_test_div <= clock_gen_pkg::DIV_NONE;
         usb_test_div <= clock_gen_pkg::DIV_NONE;
         function_and_frequency_mode <= FUNC_MODE_RESET;
         frequency_code_select <= FREQ_CODE_RESET;
      end
      else
      begin
         proc_test_div <= next_proc_div;
         bus_test_div <= next_bus_div;
         ref_test_div <= next_ref_div;
         usb_test_div <= next_usb_div;
         function_and_frequency_mode <= func_reg;
         frequency_code_select <= freq_reg;
      end
   end

endmodule

// ==== dv/clock_gen_monitor.sv ====
`timescale 1ns/10ps
module clock_gen_monitor (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic serial_data_line_out,
   input wire logic serial_data_line_oe,
   input wire logic [7:0] function_and_frequency_mode,
   input wire logic [7:0] frequency_code_select,
   input wire logic [1:0] function_mode,
   input wire logic outputs_hiz,
   input wire logic test_mode,
   input wire logic [1:0] spread_mode,
   input wire logic [16:0] proc_freq_khz,
   input wire logic [16:0] bus_freq_khz,
   input wire logic [16:0] ref_freq_khz,
   input wire logic [2:0] proc_test_div,
   input wire logic [2:0] bus_test_div,
   input wire logic [2:0] ref_test_div,
   input wire logic frame_active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // decode of the mirrored bytes
   wire live = function_mode == 2'h0 || function_mode == 2'h2;
   wire ovr = |function_and_frequency_mode[5:4];
   wire [2:0] code = frequency_code_select[2:0];
   wire fixed32 = !ovr && (code == 3'h1 || code == 3'h2);
   ////////////////////////////////////////////////////////////
   AST_OE_PULLS_LOW: assert property (serial_data_line_oe |-> !serial_data_line_out)
      else $error("data line driven high");
   AST_OE_IN_FRAME: assert property (serial_data_line_oe |-> frame_active)
      else $error("acknowledge outside a frame");
   AST_ACK_HOLD: assert property ($rose(serial_data_line_oe) |=> serial_data_line_oe[*8])
      else $error("acknowledge too short");
   AST_ACK_ENDS: assert property ($rose(serial_data_line_oe) |->
      ##[1:60] !serial_data_line_oe)
      else $error("acknowledge never released");
   AST_FUNC_FIELD: assert property ($past(resetn) |->
      function_mode == function_and_frequency_mode[1:0])
      else $error("function mode does not follow byte 0");
   AST_MODE_FLAGS: assert property ($past(resetn) |->
      outputs_hiz == (function_mode == 2'h3) && test_mode == (function_mode == 2'h1))
      else $error("mode flags wrong");
   AST_TEST_DIV: assert property ($past(resetn) && test_mode |-> proc_test_div == 3'h2 &&
      bus_test_div == 3'h4 && ref_test_div == 3'h1)
      else $error("test divide ratios wrong");
   AST_REF_LIVE: assert property ($past(resetn) && live |-> ref_freq_khz == 17'h037ee)
      else $error("reference frequency wrong");
   AST_BUS_HALF: assert property ($past(resetn) && live && !fixed32 |->
      bus_freq_khz == proc_freq_khz >> 1)
      else $error("bus clock not half");
   AST_BUS_FIXED: assert property ($past(resetn) && live && fixed32 |->
      bus_freq_khz == 17'h07d00)
      else $error("bus clock not fixed");
   AST_OVERRIDE: assert property ($past(resetn) && live && ovr |->
      proc_freq_khz == 17'h0ea60 || proc_freq_khz == 17'h10428)
      else $error("override frequency wrong");
   AST_SPREAD_FUNC: assert property (spread_mode != 2'h0 |-> function_mode == 2'h2)
      else $error("spread outside spread function");
   // main scenarios
   COV_ACK: cover property ($rose(serial_data_line_oe));
   COV_TEST: cover property (test_mode);
   COV_DOWN: cover property (spread_mode == 2'h2);
endmodule
bind clock_gen_serial_config_select clock_gen_monitor mon (.mclk, .resetn, .serial_data_line_out,
   .serial_data_line_oe, .function_and_frequency_mode, .frequency_code_select, .function_mode,
   .outputs_hiz, .test_mode, .spread_mode, .proc_freq_khz, .bus_freq_khz, .ref_freq_khz,
   .proc_test_div, .bus_test_div, .ref_test_div, .frame_active);

// ==== dv/serial_master_model.sv ====
`timescale 1ns/10ps
module serial_master_model (
   input wire logic lclk,
   input wire logic sda_level,
   output logic scl_pull,
   output logic sda_pull
);
   int lo = 1;
   // both lines released at start
   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge lclk);
   endtask
   // start or repeated start: data falls while clock high
   task automatic start_cond();
      sda_pull <= 1'b0;
      tick(lo);
      scl_pull <= 1'b0;
      tick(2);
      sda_pull <= 1'b1;
      tick(2);
      scl_pull <= 1'b1;
      tick(lo);
   endtask
   // data only changes while clock low
   task automatic send_bit(input logic b);
      sda_pull <= !b;
      tick(lo);
      scl_pull <= 1'b0;
      tick(2);
      scl_pull <= 1'b1;
      tick(1);
   endtask
   // eight bits then sample acknowledge
   task automatic send_byte(input logic [7:0] d, output logic k);
      for (int i = 7; i >= 0; i--)
         send_bit(d[i]);
      sda_pull <= 1'b0;
      tick(lo);
      scl_pull <= 1'b0;
      tick(1);
      k = !sda_level;
      tick(1);
      scl_pull <= 1'b1;
      tick(1);
   endtask
   // stop: data rises while clock high, clock left standing
   task automatic stop_cond();
      sda_pull <= 1'b1;
      tick(lo);
      scl_pull <= 1'b0;
      tick(2);
      sda_pull <= 1'b0;
      tick(2);
   endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
   logic mclk = 1'b0;
   logic lclk = 1'b0;
   logic resetn = 1'b0;
   logic freq_select_pin = 1'b0;
   logic usb_48_select = 1'b1;
   logic scl_pull, sda_pull, serial_data_line_out, serial_data_line_oe;
   logic outputs_hiz, test_mode, frame_active;
   logic [7:0] function_and_frequency_mode, frequency_code_select;
   logic [1:0] function_mode, spread_mode;
   logic [16:0] proc_freq_khz, bus_freq_khz, ref_freq_khz, usb_freq_khz;
   logic [2:0] proc_test_div, bus_test_div, ref_test_div, usb_test_div;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   // open-drain lines with pull-ups
   wire serial_clock_line = !scl_pull;
   wire serial_data_line_in = !(sda_pull || (serial_data_line_oe && !serial_data_line_out));
   // clocks
   always #2.5 mclk = ~mclk;
   always #16 lclk = ~lclk;
   clock_gen_serial_config_select dut (.mclk, .resetn, .serial_clock_line, .serial_data_line_in,
      .serial_data_line_out, .serial_data_line_oe, .freq_select_pin, .usb_48_select,
      .function_and_frequency_mode, .frequency_code_select, .function_mode, .outputs_hiz,
      .test_mode, .spread_mode, .proc_freq_khz, .bus_freq_khz, .ref_freq_khz, .usb_freq_khz,
      .proc_test_div, .bus_test_div, .ref_test_div, .usb_test_div, .frame_active);
   serial_master_model mst (.lclk(lclk), .sda_level(serial_data_line_in), .scl_pull(scl_pull),
      .sda_pull(sda_pull));
   ////////////////////////////////////////////////////////////
   task automatic summarize();
      if (bad_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [16:0] e, input logic [16:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", what, e, g);
         bad_count++;
      end
   endtask
   task automatic open_frame(input logic [7:0] a, input logic e);
      logic k;
      mst.start_cond();
      mst.send_byte(a, k);
      chk("address ack", 17'(e), 17'(k));
   endtask
   task automatic put(input logic [7:0] d, input logic e);
      logic k;
      mst.send_byte(d, k);
      chk("data ack", 17'(e), 17'(k));
   endtask
   task automatic settle();
      mst.stop_cond();
      repeat (12) @(negedge mclk);
   endtask
   task automatic write_cfg(input logic [7:0] b0, input logic [7:0] b7, input int n);
      open_frame({clock_gen_pkg::DEVICE_ADDR, 1'b0}, 1'b1);
      for (int i = 0; i < n; i++)
         put(i == 0 ? b0 : (i == 7 ? b7 : 8'h00), 1'b1);
      settle();
   endtask
   function automatic logic [16:0] proc_exp(input logic [2:0] c);
      case (c)
         3'h0, 3'h1: return clock_gen_pkg::KHZ_75_00;
         3'h2: return clock_gen_pkg::KHZ_83_31;
         3'h3: return clock_gen_pkg::KHZ_33_41;
         3'h4: return clock_gen_pkg::KHZ_50_11;
         3'h5: return clock_gen_pkg::KHZ_68_52;
         default: return clock_gen_pkg::KHZ_60_00;
      endcase
   endfunction
   // cycle ceiling
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         bad_count++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      logic [16:0] e;
      int f;
      logic live;
      repeat (2) @(negedge mclk);
      resetn = 1'b1;
      repeat (6) @(negedge mclk);
      chk("byte0", 17'(clock_gen_pkg::FUNC_MODE_RESET), 17'(function_and_frequency_mode));
      chk("byte7", 17'(clock_gen_pkg::FREQ_CODE_RESET), 17'(frequency_code_select));
      chk("proc", clock_gen_pkg::KHZ_60_00, proc_freq_khz);
      chk("usb", clock_gen_pkg::KHZ_48_00, usb_freq_khz);
      chk("idle", 17'h0, {15'h0, frame_active, serial_data_line_oe});
      // every code, nine bytes so one lands past the end
      for (int c = 0; c < 8; c++)
      begin
         mst.lo = (c == 3) ? 4 : 1;
         write_cfg(8'h00, 8'(c), 9);
         e = proc_exp(3'(c));
         chk("proc", e, proc_freq_khz);
         chk("bus", (c == 1 || c == 2) ? clock_gen_pkg::KHZ_32_00 : e >> 1, bus_freq_khz);
      end
      freq_select_pin = 1'b1;
      repeat (6) @(negedge mclk);
      chk("proc pin", clock_gen_pkg::KHZ_66_82, proc_freq_khz);
      // override bits hide the code, pin picks
      for (int i = 2; i < 8; i++)
      begin
         freq_select_pin = i[0];
         write_cfg({2'h0, 2'(i >> 1), 4'h2}, 8'h00, 1);
         e = i[0] ? clock_gen_pkg::KHZ_66_60 : clock_gen_pkg::KHZ_60_00;
         chk("override proc", e, proc_freq_khz);
         chk("spread", i[0] ? 17'h2 : 17'h1, 17'(spread_mode));
         chk("byte7", 17'h7, 17'(frequency_code_select));
      end
      // output functions with both USB clock selections
      for (int i = 0; i < 8; i++)
      begin
         usb_48_select = i[0];
         f = i >> 1;
         live = (f == 0 || f == 2);
         write_cfg(8'(f), 8'h00, 1);
         chk("mode", {13'h0, 2'(f), f == 3, f == 1},
            {13'h0, function_mode, outputs_hiz, test_mode});
         chk("ref", live ? clock_gen_pkg::KHZ_14_318 : 17'h0, ref_freq_khz);
         chk("spread", f == 2 ? 17'h1 : 17'h0, 17'(spread_mode));
         e = i[0] ? clock_gen_pkg::KHZ_48_00 : clock_gen_pkg::KHZ_24_00;
         chk("usb", live ? e : 17'h0, usb_freq_khz);
         chk("div", f == 1 ? {5'h0, 9'h0a1, i[0] ? 3'h2 : 3'h4} : 17'h0,
            {5'h0, proc_test_div, bus_test_div, ref_test_div, usb_test_div});
      end
      // refused frames leave byte 0 at 8'h03
      open_frame({clock_gen_pkg::DEVICE_ADDR ^ 7'h01, 1'b0}, 1'b0);
      put(8'h00, 1'b0);
      settle();
      open_frame({clock_gen_pkg::DEVICE_ADDR, 1'b1}, 1'b0);
      put(8'h00, 1'b0);
      settle();
      chk("byte0", 17'h3, 17'(function_and_frequency_mode));
      // repeated start begins again at byte 0
      open_frame({clock_gen_pkg::DEVICE_ADDR, 1'b0}, 1'b1);
      put(8'h01, 1'b1);
      repeat (2) @(negedge mclk);
      chk("byte0", 17'h1, 17'(function_and_frequency_mode));
      open_frame({clock_gen_pkg::DEVICE_ADDR, 1'b0}, 1'b1);
      put(8'h02, 1'b1);
      settle();
      chk("byte0", 17'h2, 17'(function_and_frequency_mode));
      // truncated byte, stop clock adds a zero bit
      open_frame({clock_gen_pkg::DEVICE_ADDR, 1'b0}, 1'b1);
      mst.send_bit(1'b1);
      mst.send_bit(1'b1);
      repeat (3) @(negedge mclk);
      chk("early bits", 17'h3, 17'(function_and_frequency_mode[7:6]));
      settle();
      chk("byte0", 17'hc2, 17'(function_and_frequency_mode));
      chk("byte7", 17'h7, 17'(frequency_code_select));
      summarize();
   end
endmodule
